// File: shared/ptr_pkg.sv
// package: command codes, formats, reset values and limits for telemetry
package ptr_pkg;

    // read-word command codes
    localparam logic [7:0] CMD_IN_VOLT       = 8'h88;
    localparam logic [7:0] CMD_IN_CURR       = 8'h89;
    localparam logic [7:0] CMD_IN_POWER      = 8'h97;
    localparam logic [7:0] CMD_OUT_VOLT      = 8'h8B;
    localparam logic [7:0] CMD_OUT_CURR      = 8'h8C;
    localparam logic [7:0] CMD_CHAN_TEMP     = 8'h8D;
    localparam logic [7:0] CMD_DIE_TEMP      = 8'h8E;
    localparam logic [7:0] CMD_OUT_POWER     = 8'h96;
    localparam logic [7:0] CMD_CHANNEL_CURRENT_FIXED_POINT = 8'hBB;
    localparam logic [7:0] CMD_IN_CURR_PEAK  = 8'hC4;
    localparam logic [7:0] CMD_IN_CURR_MIN   = 8'hC5;
    localparam logic [7:0] CMD_IN_POWER_PEAK = 8'hC6;
    localparam logic [7:0] CMD_IN_POWER_MIN  = 8'hC7;
    localparam logic [7:0] CMD_RAW_CURRENT_SENSE_VOLTAGE = 8'hFA;

    // tracker load values and idle read word, linear 11-bit format
    localparam logic [15:0] PEAK_RESET = 16'h7C00;
    localparam logic [15:0] MIN_RESET  = 16'h7BFF;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // linear 11-bit field layout
    localparam int L11_EXP_LSB  = 11;
    localparam int L11_MANT_MSB = 10;
    localparam logic signed [6:0] L11_EXP_MIN = -7'sh10;
    localparam logic signed [6:0] L11_EXP_MAX = 7'sh0F;
    localparam logic signed [21:0] L11_MANT_MAX = 22'sh3FF;
    localparam logic signed [21:0] L11_MANT_MIN = -22'sh400;
    localparam logic signed [6:0] FIX_FRAC_BITS = 7'sh10;

    // alternate current: counts per ampere (1 count = 2.5 mA)
    localparam logic signed [63:0] ALT_COUNTS_PER_AMP = 64'sh190;
    localparam logic signed [63:0] ALT_MAX = 64'sh7FFF;
    localparam logic signed [63:0] ALT_MIN = -64'sh8000;

    // diode ideality above this marks the external sensor invalid
    localparam logic [15:0] DIODE_IDEALITY_LIMIT = 16'h1000;

    localparam int NUM_CHAN = 2;

    typedef enum logic [2:0] {
        CK_IN_VOLT  = 3'h0,
        CK_IN_CURR  = 3'h1,
        CK_OUT_VOLT = 3'h3,
        CK_OUT_CURR = 3'h2,
        CK_OUT_PWR  = 3'h6,
        CK_EXT_TEMP = 3'h7,
        CK_DIE_TEMP = 3'h5
    } ptr_kind_t;

endpackage

// File: shared/ptr_mul_if.sv
// interface: operands and product of the linear-format multiplier
`timescale 1ns/1ps
interface ptr_mul_if;
    logic        start;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] prod;
    logic        done;
    modport ctl (output start, output opa, output opb,
                 input prod, input done);
    modport mul (input start, input opa, input opb,
                 output prod, output done);
endinterface

// File: verilog/ptr_l11_mul.sv
// module: registered multiplier of two linear 11-bit format words
`timescale 1ns/1ps
module ptr_l11_mul (
    input  wire logic  i_clk,     // core clock
    input  wire logic  i_rst_n,   // async reset, active low
    ptr_mul_if.mul     mb         // operands in, product out
);

    typedef struct packed {
        logic [15:0] prod;
        logic        done;
    } ptr_mul_st_t;

    ptr_mul_st_t st_ff;
    ptr_mul_st_t nxt_st;

    function automatic logic [15:0] l11_mul(input logic [15:0] a,
                                            input logic [15:0] b);
        logic signed [21:0] p;
        logic signed [6:0]  e;
        p = 22'($signed(a[ptr_pkg::L11_MANT_MSB:0]))
            * 22'($signed(b[ptr_pkg::L11_MANT_MSB:0]));
        e = 7'($signed(a[15:ptr_pkg::L11_EXP_LSB]))
            + 7'($signed(b[15:ptr_pkg::L11_EXP_LSB]));
        // renormalise into an 11-bit mantissa and legal exponent
        for (int k = 0; k < 24; k++) begin
            if (p > ptr_pkg::L11_MANT_MAX || p < ptr_pkg::L11_MANT_MIN
                || e < ptr_pkg::L11_EXP_MIN) begin
                p = p >>> 1;
                e = e + 7'sh01;
            end
        end
        if (e > ptr_pkg::L11_EXP_MAX) begin
            e = ptr_pkg::L11_EXP_MAX;
            p = p[21] ? ptr_pkg::L11_MANT_MIN : ptr_pkg::L11_MANT_MAX;
        end
        return {e[4:0], p[10:0]};
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = mb.start;
        if (mb.start) begin
            nxt_st.prod = l11_mul(mb.opa, mb.opb);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mb.prod = st_ff.prod;
    assign mb.done = st_ff.done;

endmodule

// File: verilog/ptr_readout.sv
// module: telemetry readout, trackers and read-word command answers
//
// How it works
// - input voltage read returns latest conversion
// - input current rescaled by two-bit range setting
// - input power is current times voltage
// - peaks load 0x7C00 on reset, clear, turn-on
// - minimums load 0x7BFF on reset, clear, turn-on
// - channel temperature in use feeds the paged channel temperature read, O_TEMP_CH0 and O_TEMP_CH1
// - invalid external sensor replaced by die temperature
// - die temperature is read directly and also feeds an invalid channel's temperature
// - paged output voltage and current returned
// - paged output power returned in watts
// - alternate current signed, one count 2.5 mA
// - alternate current clamps at plus/minus 81.92 A
// - raw sense voltage magnitude, no temperature correction
// - raw sense voltage unsigned, scale set by select
// - every value answered as a 16-bit read word
`timescale 1ns/1ps
module ptr_readout (
    input  wire logic              I_MCLK,         // core clock, 250 MHz
    input  wire logic              I_RST_N,        // async reset, low
    input  wire logic              I_CONV_VALID,   // new conversion pulse
    input  wire ptr_pkg::ptr_kind_t I_CONV_KIND,   // which quantity
    input  wire logic              I_CONV_CHAN,    // channel of result
    input  wire logic [15:0]       I_CONV_DATA,    // result word
    input  wire logic [15:0]       I_CONV_AUX,     // sense raw / ideality
    input  wire logic              I_CONV_STUCK,   // sense pin constant
    input  wire logic [1:0]        I_IIN_RANGE,    // input current range
    input  wire logic [1:0]        I_CHAN_ON,      // channel on levels
    input  wire logic              I_CLEAR_FAULTS, // clear-faults pulse
    input  wire logic              I_RD_REQ,       // read-word request
    input  wire logic [7:0]        I_RD_CMD,       // command code
    input  wire logic [7:0]        I_RD_PAGE,      // selected page
    output logic                   O_RD_ACK,       // answer pulse
    output logic [15:0]            O_RD_DATA,      // answer word
    output logic                   O_RD_ERR,       // unsupported read
    output logic [15:0]            O_TEMP_CH0,     // temperature in use
    output logic [15:0]            O_TEMP_CH1      // temperature in use
);

    localparam int NC = ptr_pkg::NUM_CHAN;

    typedef struct packed {
        logic [15:0]         vin;
        logic [15:0]         iin;
        logic [15:0]         pin;
        logic [15:0]         iin_pk;
        logic [15:0]         iin_mn;
        logic [15:0]         pin_pk;
        logic [15:0]         pin_mn;
        logic [NC-1:0][15:0] vout;
        logic [NC-1:0][15:0] iout;
        logic [NC-1:0][15:0] pout;
        logic [NC-1:0][15:0] ext_t;
        logic [NC-1:0]       ext_bad;
        logic [NC-1:0][15:0] temp_use;
        logic [NC-1:0][15:0] sense;
        logic [NC-1:0][15:0] alt;
        logic [15:0]         die_t;
        logic [NC-1:0]       on_prev;
        logic                mul_go;
        logic                rd_ack;
        logic                rd_err;
        logic [15:0]         rd_data;
    } ptr_st_t;

    ptr_st_t st_ff;
    ptr_st_t nxt_st;

    ptr_mul_if mbus ();

    ptr_l11_mul u_mul (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RST_N),
        .mb      (mbus.mul)
    );

    assign mbus.start = st_ff.mul_go;
    assign mbus.opa   = st_ff.iin;
    assign mbus.opb   = st_ff.vin;

    ////////////////////////////////////////////////////////////////////////

    // linear word to signed fixed point with 16 fraction bits
    function automatic logic signed [47:0] to_fix(input logic [15:0] v);
        logic signed [47:0] m;
        logic signed [6:0]  sh;
        m  = 48'($signed(v[ptr_pkg::L11_MANT_MSB:0]));
        sh = 7'($signed(v[15:ptr_pkg::L11_EXP_LSB]))
             + ptr_pkg::FIX_FRAC_BITS;
        return m <<< sh[5:0];
    endfunction

    // lower the exponent by the range code, keeping it legal
    function automatic logic [15:0] range_fix(input logic [15:0] v,
                                              input logic [1:0]  r);
        logic signed [10:0] m;
        logic signed [6:0]  e;
        m = $signed(v[ptr_pkg::L11_MANT_MSB:0]);
        e = 7'($signed(v[15:ptr_pkg::L11_EXP_LSB])) - 7'($unsigned(r));
        for (int k = 0; k < 4; k++) begin
            if (e < ptr_pkg::L11_EXP_MIN) begin
                m = m >>> 1;
                e = e + 7'sh01;
            end
        end
        return {e[4:0], m};
    endfunction

    // current word to 2.5 mA counts, saturated
    function automatic logic [15:0] alt_cur(input logic [15:0] v);
        logic signed [63:0] t;
        t = 64'(to_fix(v)) * ptr_pkg::ALT_COUNTS_PER_AMP;
        t = t >>> ptr_pkg::FIX_FRAC_BITS;
        if (t > ptr_pkg::ALT_MAX) begin
            t = ptr_pkg::ALT_MAX;
        end else if (t < ptr_pkg::ALT_MIN) begin
            t = ptr_pkg::ALT_MIN;
        end
        return t[15:0];
    endfunction

    function automatic logic [15:0] abs16(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    function automatic logic is_gt(input logic [15:0] a,
                                   input logic [15:0] b);
        return to_fix(a) > to_fix(b);
    endfunction

    ////////////////////////////////////////////////////////////////////////

    logic [NC-1:0] turn_on;
    logic          trk_load;
    logic          pg;
    logic          pg_ok;
    logic [15:0]   iin_new;

    always_comb begin
        nxt_st   = st_ff;
        turn_on  = I_CHAN_ON & ~st_ff.on_prev;
        trk_load = I_CLEAR_FAULTS | (|turn_on);
        pg       = I_RD_PAGE[0];
        pg_ok    = (I_RD_PAGE < 8'(NC));
        iin_new  = range_fix(I_CONV_DATA, I_IIN_RANGE);

        nxt_st.on_prev = I_CHAN_ON;
        nxt_st.mul_go  = 1'b0;

        // new results from the converter
        if (I_CONV_VALID) begin
            case (I_CONV_KIND)
                ptr_pkg::CK_IN_VOLT: begin
                    nxt_st.vin    = I_CONV_DATA;
                    nxt_st.mul_go = 1'b1;
                end
                ptr_pkg::CK_IN_CURR: begin
                    nxt_st.iin    = iin_new;
                    nxt_st.mul_go = 1'b1;
                    if (is_gt(iin_new, st_ff.iin_pk)) begin
                        nxt_st.iin_pk = iin_new;
                    end
                    if (is_gt(st_ff.iin_mn, iin_new)) begin
                        nxt_st.iin_mn = iin_new;
                    end
                end
                ptr_pkg::CK_OUT_VOLT: begin
                    nxt_st.vout[I_CONV_CHAN] = I_CONV_DATA;
                end
                ptr_pkg::CK_OUT_CURR: begin
                    nxt_st.iout[I_CONV_CHAN] = I_CONV_DATA;
                    nxt_st.alt[I_CONV_CHAN] =
                        alt_cur(I_CONV_DATA);
                    // raw counts, scale fixed by the monitor select
                    nxt_st.sense[I_CONV_CHAN] =
                        abs16(I_CONV_AUX);
                end
                ptr_pkg::CK_OUT_PWR: begin
                    nxt_st.pout[I_CONV_CHAN] = I_CONV_DATA;
                end
                ptr_pkg::CK_EXT_TEMP: begin
                    nxt_st.ext_t[I_CONV_CHAN] = I_CONV_DATA;
                    nxt_st.ext_bad[I_CONV_CHAN] = I_CONV_STUCK
                        | (I_CONV_AUX > ptr_pkg::DIODE_IDEALITY_LIMIT);
                end
                ptr_pkg::CK_DIE_TEMP: begin
                    nxt_st.die_t = I_CONV_DATA;
                end
                default: begin
                    nxt_st.mul_go = 1'b0;
                end
            endcase
        end

        // input power from the multiplier
        if (mbus.done) begin
            nxt_st.pin = mbus.prod;
            if (is_gt(mbus.prod, st_ff.pin_pk)) begin
                nxt_st.pin_pk = mbus.prod;
            end
            if (is_gt(st_ff.pin_mn, mbus.prod)) begin
                nxt_st.pin_mn = mbus.prod;
            end
        end

        // tracker reload wins over a same-cycle update
        if (trk_load) begin
            nxt_st.iin_pk = ptr_pkg::PEAK_RESET;
            nxt_st.pin_pk = ptr_pkg::PEAK_RESET;
            nxt_st.iin_mn = ptr_pkg::MIN_RESET;
            nxt_st.pin_mn = ptr_pkg::MIN_RESET;
        end

        // die temperature only stands in for an invalid channel sensor
        for (int c = 0; c < NC; c++) begin
            nxt_st.temp_use[c] = nxt_st.ext_bad[c] ? nxt_st.die_t
                                                   : nxt_st.ext_t[c];
        end

        // read-word answers, one cycle after the request
        nxt_st.rd_ack  = I_RD_REQ;
        nxt_st.rd_err  = 1'b0;
        nxt_st.rd_data = ptr_pkg::WORD_RESET;
        if (I_RD_REQ) begin
            case (I_RD_CMD)
                ptr_pkg::CMD_IN_VOLT: begin
                    nxt_st.rd_data = st_ff.vin;
                end
                ptr_pkg::CMD_IN_CURR: begin
                    nxt_st.rd_data = st_ff.iin;
                end
                ptr_pkg::CMD_IN_POWER: begin
                    nxt_st.rd_data = st_ff.pin;
                end
                ptr_pkg::CMD_IN_CURR_PEAK: begin
                    nxt_st.rd_data = st_ff.iin_pk;
                end
                ptr_pkg::CMD_IN_CURR_MIN: begin
                    nxt_st.rd_data = st_ff.iin_mn;
                end
                ptr_pkg::CMD_IN_POWER_PEAK: begin
                    nxt_st.rd_data = st_ff.pin_pk;
                end
                ptr_pkg::CMD_IN_POWER_MIN: begin
                    nxt_st.rd_data = st_ff.pin_mn;
                end
                ptr_pkg::CMD_DIE_TEMP: begin
                    nxt_st.rd_data = st_ff.die_t;
                end
                ptr_pkg::CMD_OUT_VOLT: begin
                    nxt_st.rd_data = st_ff.vout[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                ptr_pkg::CMD_OUT_CURR: begin
                    nxt_st.rd_data = st_ff.iout[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                ptr_pkg::CMD_OUT_POWER: begin
                    nxt_st.rd_data = st_ff.pout[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                ptr_pkg::CMD_CHAN_TEMP: begin
                    nxt_st.rd_data = st_ff.temp_use[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                ptr_pkg::CMD_CHANNEL_CURRENT_FIXED_POINT: begin
                    nxt_st.rd_data = st_ff.alt[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                ptr_pkg::CMD_RAW_CURRENT_SENSE_VOLTAGE: begin
                    nxt_st.rd_data = st_ff.sense[pg];
                    nxt_st.rd_err  = !pg_ok;
                end
                default: begin
                    nxt_st.rd_err = 1'b1;
                end
            endcase
            if (nxt_st.rd_err) begin
                nxt_st.rd_data = ptr_pkg::WORD_RESET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge I_MCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_ff        <= '0;
            st_ff.iin_pk <= ptr_pkg::PEAK_RESET;
            st_ff.pin_pk <= ptr_pkg::PEAK_RESET;
            st_ff.iin_mn <= ptr_pkg::MIN_RESET;
            st_ff.pin_mn <= ptr_pkg::MIN_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_RD_ACK   = st_ff.rd_ack;
    assign O_RD_DATA  = st_ff.rd_data;
    assign O_RD_ERR   = st_ff.rd_err;
    assign O_TEMP_CH0 = st_ff.temp_use[0];
    assign O_TEMP_CH1 = st_ff.temp_use[1];

endmodule

// File: tb/ptr_host_model.sv
// model: management host issuing read-word telemetry requests
`timescale 1ns/1ps
module ptr_host_model (
    input  wire logic        i_clk,  // core clock
    input  wire logic        i_ack,  // answer pulse
    input  wire logic [15:0] i_data, // answer word
    input  wire logic        i_err,  // refused flag
    output logic             o_req,  // read request
    output logic [7:0]       o_cmd,  // command code
    output logic [7:0]       o_page  // selected page
);
    initial begin
        o_req  = 1'b0;
        o_cmd  = 8'h00;
        o_page = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // one request pulse, answer taken the cycle after it is accepted;
    // once the pulse ends, command and page are driven inverted until
    // the next request
    task automatic read(input logic [7:0] cmd, input logic [7:0] page,
                        output logic [15:0] data, output logic err,
                        output logic ok);
        @(negedge i_clk);
        o_req  = 1'b1;
        o_cmd  = cmd;
        o_page = page;
        @(negedge i_clk);
        o_req  = 1'b0;
        o_cmd  = ~cmd;
        o_page = ~page;
        ok     = i_ack;
        data   = i_data;
        err    = i_err;
    endtask
endmodule

// File: tb/ptr_readout_chk.sv
// checker: read answers, tracker reload and temperature in use
`timescale 1ns/1ps
module ptr_readout_chk (
    input wire logic               I_MCLK,         // clock
    input wire logic               I_RST_N,        // reset, low
    input wire logic               I_CONV_VALID,   // new result
    input wire ptr_pkg::ptr_kind_t I_CONV_KIND,    // quantity
    input wire logic               I_CONV_CHAN,    // channel
    input wire logic [15:0]        I_CONV_DATA,    // result
    input wire logic [15:0]        I_CONV_AUX,     // ideality
    input wire logic               I_CONV_STUCK,   // pin stuck
    input wire logic               I_CLEAR_FAULTS, // clear pulse
    input wire logic               I_RD_REQ,       // request
    input wire logic [7:0]         I_RD_CMD,       // code
    input wire logic [7:0]         I_RD_PAGE,      // page
    input wire logic               O_RD_ACK,       // answer
    input wire logic [15:0]        O_RD_DATA,      // word
    input wire logic               O_RD_ERR,       // refused
    input wire logic [15:0]        O_TEMP_CH0      // temp in use
);
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RST_N);

    logic ext0_ok;
    logic temp_conv;
    assign ext0_ok = I_CONV_VALID && I_CONV_KIND == ptr_pkg::CK_EXT_TEMP
                     && !I_CONV_CHAN && !I_CONV_STUCK
                     && I_CONV_AUX <= ptr_pkg::DIODE_IDEALITY_LIMIT;
    assign temp_conv = I_CONV_VALID && (I_CONV_KIND == ptr_pkg::CK_EXT_TEMP
                       || I_CONV_KIND == ptr_pkg::CK_DIE_TEMP);

    ////////////////////////////////////////////////////////////////////
    ack_after_req_a:
    assert property (I_RD_REQ |=> O_RD_ACK)
        else $error("no answer one cycle after request");
    ack_needs_req_a:
    assert property (O_RD_ACK |-> $past(I_RD_REQ))
        else $error("answer without request");
    idle_word_zero_a:
    assert property (!O_RD_ACK |-> O_RD_DATA == 16'h0000 && !O_RD_ERR)
        else $error("answer lines not idle");
    err_data_zero_a:
    assert property (O_RD_ERR |-> O_RD_ACK && O_RD_DATA == 16'h0000)
        else $error("refusal carries data");
    bad_page_err_a:
    assert property (I_RD_REQ && I_RD_CMD == ptr_pkg::CMD_OUT_VOLT
        && I_RD_PAGE > 8'h01 |=> O_RD_ERR)
        else $error("page above one not refused");
    clear_peak_a:
    assert property (I_CLEAR_FAULTS ##1 !I_CONV_VALID ##1 I_RD_REQ
        && I_RD_CMD == ptr_pkg::CMD_IN_CURR_PEAK
        |=> O_RD_DATA == ptr_pkg::PEAK_RESET)
        else $error("peak not reloaded by clear");
    clear_min_a:
    assert property (!I_CONV_VALID ##1 I_CLEAR_FAULTS ##1 !I_CONV_VALID
        ##1 I_RD_REQ
        && I_RD_CMD == ptr_pkg::CMD_IN_POWER_MIN
        |=> O_RD_DATA == ptr_pkg::MIN_RESET)
        else $error("minimum not reloaded by clear");
    vin_latest_a:
    assert property (I_CONV_VALID && I_CONV_KIND == ptr_pkg::CK_IN_VOLT
        ##1 !I_CONV_VALID ##1 I_RD_REQ && I_RD_CMD == ptr_pkg::CMD_IN_VOLT
        |=> O_RD_DATA == $past(I_CONV_DATA, 3))
        else $error("input voltage not latest result");
    ext_temp_use_a:
    assert property (ext0_ok |=> O_TEMP_CH0 == $past(I_CONV_DATA))
        else $error("valid external temp not in use");
    temp_hold_a:
    assert property (!temp_conv |=> $stable(O_TEMP_CH0))
        else $error("temperature changed without result");

    clear_seen_c: cover property (I_CLEAR_FAULTS);
    refuse_seen_c: cover property (O_RD_ACK && O_RD_ERR);
    stuck_seen_c: cover property (I_CONV_VALID && I_CONV_STUCK);
endmodule

bind ptr_readout ptr_readout_chk chk_u (
    .I_MCLK, .I_RST_N, .I_CONV_VALID, .I_CONV_KIND, .I_CONV_CHAN,
    .I_CONV_DATA, .I_CONV_AUX, .I_CONV_STUCK, .I_CLEAR_FAULTS, .I_RD_REQ,
    .I_RD_CMD, .I_RD_PAGE, .O_RD_ACK, .O_RD_DATA, .O_RD_ERR, .O_TEMP_CH0
);

// File: tb/tb_power_telemetry_readout.sv
// testbench: telemetry readout answers, trackers and temperature use
`timescale 1ns/1ps
module tb_power_telemetry_readout;
    typedef struct packed {
        logic [2:0]  kind;
        logic [15:0] data;
        logic [15:0] aux;
        logic [7:0]  cmd;
        logic        page;
        logic [15:0] exp;
    } ptr_row_t;

    logic               mclk, rst_n, cv_valid, cv_chan, cv_stuck, clr;
    ptr_pkg::ptr_kind_t cv_kind;
    logic [15:0]        cv_data, cv_aux, rd_data, temp0, temp1, d;
    logic [1:0]         iin_range, chan_on;
    logic [7:0]         rd_cmd, rd_page;
    logic               rd_req, rd_ack, rd_err, e;
    int                 fails, samples_checked;
    ptr_row_t           rows [11];

    ptr_readout dut_u (.I_MCLK(mclk), .I_RST_N(rst_n),
        .I_CONV_VALID(cv_valid), .I_CONV_KIND(cv_kind), .I_CONV_CHAN(cv_chan),
        .I_CONV_DATA(cv_data), .I_CONV_AUX(cv_aux), .I_CONV_STUCK(cv_stuck),
        .I_IIN_RANGE(iin_range), .I_CHAN_ON(chan_on), .I_CLEAR_FAULTS(clr),
        .I_RD_REQ(rd_req), .I_RD_CMD(rd_cmd), .I_RD_PAGE(rd_page),
        .O_RD_ACK(rd_ack), .O_RD_DATA(rd_data), .O_RD_ERR(rd_err),
        .O_TEMP_CH0(temp0), .O_TEMP_CH1(temp1));
    ptr_host_model host_u (.i_clk(mclk), .i_ack(rd_ack), .i_data(rd_data),
        .i_err(rd_err), .o_req(rd_req), .o_cmd(rd_cmd), .o_page(rd_page));

    ////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic real l11(input logic [15:0] w);
        return $itor($signed(w[10:0])) * (2.0 ** $signed(w[15:11]));
    endfunction

    task automatic conv(input logic [2:0] k, input logic ch,
                        input logic [15:0] dt, input logic [15:0] a,
                        input logic st);
        @(negedge mclk);
        cv_valid = 1'b1;
        cv_kind  = ptr_pkg::ptr_kind_t'(k);
        cv_chan  = ch;
        cv_data  = dt;
        cv_aux   = a;
        cv_stuck = st;
        @(negedge mclk);
        cv_valid = 1'b0;
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] p);
        logic ok;
        host_u.read(c, p, d, e, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("Error at %0t: no answer", $time);
            results();
        end
    endtask

    task automatic rdchk(input logic [7:0] c, input logic [7:0] p,
                         input logic [15:0] exp);
        rd(c, p);
        chk(d, exp);
        chk({15'h0000, e}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        {rst_n, cv_valid, cv_chan, cv_stuck, clr} = 5'h00;
        cv_kind   = ptr_pkg::CK_IN_VOLT;
        {cv_data, cv_aux} = 32'h0000_0000;
        iin_range = 2'h0;
        chan_on   = 2'h0;
        rows = '{
            '{3'h0, 16'h0123, 16'h0000, 8'h88, 1'b0, 16'h0123},
            '{3'h3, 16'h4567, 16'h0000, 8'h8B, 1'b1, 16'h4567},
            '{3'h2, 16'h0005, 16'hFE06, 8'hBB, 1'b0, 16'h07D0},
            '{3'h2, 16'h0005, 16'hFE06, 8'hFA, 1'b0, 16'h01FA},
            '{3'h2, 16'h03FF, 16'h0000, 8'hBB, 1'b1, 16'h7FFF},
            '{3'h2, 16'h0401, 16'h0000, 8'hBB, 1'b1, 16'h8000},
            '{3'h2, 16'hFFFF, 16'h0000, 8'hBB, 1'b0, 16'hFF38},
            '{3'h2, 16'h0005, 16'h01FA, 8'h8C, 1'b1, 16'h0005},
            '{3'h6, 16'h0042, 16'h0000, 8'h96, 1'b0, 16'h0042},
            '{3'h7, 16'h0019, 16'h1000, 8'h8D, 1'b1, 16'h0019},
            '{3'h5, 16'h0028, 16'h0000, 8'h8E, 1'b0, 16'h0028}
        };
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            conv(rows[i].kind, rows[i].page, rows[i].data, rows[i].aux, 1'b0);
            rdchk(rows[i].cmd, {7'h00, rows[i].page}, rows[i].exp);
        end
        $display("table done");
        iin_range = 2'h2;
        conv(3'h1, 1'b0, 16'h0100, 16'h0000, 1'b0);
        rdchk(8'h89, 8'h00, 16'hF100);
        iin_range = 2'h0;
        @(negedge mclk);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        rdchk(8'hC4, 8'h00, 16'h7C00);
        @(negedge mclk);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        rdchk(8'hC7, 8'h00, 16'h7BFF);
        conv(3'h0, 1'b0, 16'h0002, 16'h0000, 1'b0);
        conv(3'h1, 1'b0, 16'h0003, 16'h0000, 1'b0);
        repeat (4) @(negedge mclk);
        rd(8'h97, 8'h00);
        chk({15'h0000, l11(d) == 6.0}, 16'h0001);
        conv(3'h1, 1'b0, 16'h0100, 16'h0000, 1'b0);
        conv(3'h1, 1'b0, 16'h0080, 16'h0000, 1'b0);
        rdchk(8'hC4, 8'h00, 16'h0100);
        rdchk(8'hC5, 8'h00, 16'h0003);
        @(negedge mclk);
        chan_on = 2'h2;
        rdchk(8'hC6, 8'h00, 16'h7C00);
        rdchk(8'hC5, 8'h00, 16'h7BFF);
        $display("trackers done");
        conv(3'h5, 1'b0, 16'h0030, 16'h0000, 1'b0);
        conv(3'h7, 1'b0, 16'h0019, 16'h1001, 1'b0);
        @(negedge mclk);
        chk(temp0, 16'h0030);
        rdchk(8'h8D, 8'h00, 16'h0030);
        conv(3'h7, 1'b1, 16'h0019, 16'h0000, 1'b1);
        @(negedge mclk);
        chk(temp1, 16'h0030);
        conv(3'h7, 1'b0, 16'h001A, 16'h0000, 1'b0);
        conv(3'h5, 1'b0, 16'h0031, 16'h0000, 1'b0);
        @(negedge mclk);
        chk(temp0, 16'h001A);
        $display("temperature done");
        rd(8'h8B, 8'h02);
        chk({e, d[14:0]}, 16'h8000);
        rd(8'h00, 8'h00);
        chk({e, d[14:0]}, 16'h8000);
        $display("refusal done");
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk(temp0, 16'h0000);
        rst_n = 1'b1;
        rdchk(8'hC4, 8'h00, 16'h7C00);
        rdchk(8'hC5, 8'h00, 16'h7BFF);
        rdchk(8'hC6, 8'h00, 16'h7C00);
        rdchk(8'hC7, 8'h00, 16'h7BFF);
        $display("reset done");
        results();
    end
endmodule
